// File: rtl/iocf_pkg.sv
// Shared constants and types for the I/O pin configuration and DAC write block.
package iocf_pkg;

    // ------------------------------------------------------------------
    // Pointer byte decoding
    // ------------------------------------------------------------------
    localparam logic [3:0] PTR_MODE_CFG = 4'h0;  // Upper nibble of a control write.
    localparam logic [3:0] PTR_MODE_DAC = 4'h1;  // Upper nibble of a DAC write.

    // ------------------------------------------------------------------
    // Control register select codes (low nibble of the pointer byte)
    // ------------------------------------------------------------------
    localparam logic [3:0] REG_GPCTL = 4'h3;   // General control word.
    localparam logic [3:0] REG_ADC = 4'h4;     // ADC pin function.
    localparam logic [3:0] REG_DAC = 4'h5;     // DAC pin function.
    localparam logic [3:0] REG_PD = 4'h6;      // Pull-down pin function.
    localparam logic [3:0] REG_LOAD_TRANSFER_MODE = 4'h7;    // Load transfer mode.
    localparam logic [3:0] REG_GPO = 4'h8;     // GPIO output pin function.
    localparam logic [3:0] REG_GPDATA = 4'h9;  // GPIO output data.
    localparam logic [3:0] REG_GPI = 4'ha;     // GPIO input pin function.
    localparam logic [3:0] REG_OD = 4'hc;      // Open-drain selection.
    localparam logic [3:0] REG_TRI = 4'hd;     // Three-state pin function.
    localparam logic [3:0] REG_SWRST = 4'hf;   // Software reset.

    // ------------------------------------------------------------------
    // General control word field positions and reset values
    // ------------------------------------------------------------------
    localparam int GP_PRECHARGE_BIT = 9;
    localparam int GP_BUFEN_BIT = 8;
    localparam int GP_LOCK_BIT = 7;
    localparam int GP_WRALL_BIT = 6;
    localparam int GP_ADCRANGE_BIT = 5;
    localparam int GP_DACRANGE_BIT = 4;
    localparam logic [15:0] GPCTL_RESET = 16'h0000;
    localparam logic [15:0] PD_RESET = 16'h00ff;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam int DAC_CODE_W = 12;

    // ------------------------------------------------------------------
    // Load transfer mode codes
    // ------------------------------------------------------------------
    localparam logic [1:0] LOAD_TRANSFER_MODE_AUTO = 2'h0;   // Copy at once.
    localparam logic [1:0] LOAD_TRANSFER_MODE_HOLD = 2'h1;   // Keep in input registers.
    localparam logic [1:0] LOAD_TRANSFER_MODE_PULSE = 2'h2;  // Copy all, then hold.

    // Resolved function of one channel.
    typedef enum logic [2:0] {
        FN_PD = 3'h0,
        FN_DAC = 3'h1,
        FN_ADC = 3'h2,
        FN_DACADC = 3'h3,
        FN_GPO = 3'h4,
        FN_GPI = 3'h5,
        FN_GPBOTH = 3'h6,
        FN_TRI = 3'h7
    } iocf_fn_t;

endpackage

// File: rtl/iocf_frame_rx.sv
// Assembles a pointer byte and two data bytes into one write command.
module iocf_frame_rx
    import iocf_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Received bytes from the serial front end.
    input wire logic frameStart,
    input wire logic byteValid,
    input wire logic [7:0] byteData,
    // Assembled command.
    output logic cmdValid,
    output logic [7:0] cmdPtr,
    output logic [15:0] cmdData
);

    // Byte position inside the frame; 3 means the frame is complete.
    logic [1:0] bytePos;

    // Count bytes; a new start always restarts the frame so that a short
    // frame is dropped instead of mixing with the next one.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bytePos <= 2'h0;
        end else if (frameStart) begin
            bytePos <= 2'h0;
        end else if (byteValid && bytePos != 2'h3) begin
            bytePos <= bytePos + 2'h1;
        end
    end

    // Capture pointer and data bytes, most significant first.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmdPtr <= 8'h00;
            cmdData <= 16'h0000;
        end else if (byteValid && !frameStart) begin
            if (bytePos == 2'h0) begin
                cmdPtr <= byteData;
            end else if (bytePos == 2'h1) begin
                cmdData[15:8] <= byteData;
            end else if (bytePos == 2'h2) begin
                cmdData[7:0] <= byteData;
            end
        end
    end

    // One-cycle pulse once the least significant byte has landed.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmdValid <= 1'b0;
        end else begin
            cmdValid <= byteValid && !frameStart && bytePos == 2'h2;
        end
    end

endmodule

// File: rtl/iocf_pin_cell.sv
// Function state of one I/O channel; a later write overrides, except that the DAC/ADC and GPIO in/out pairs merge.
module iocf_pin_cell
    import iocf_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Accepted configuration write.
    input wire logic wrEn,
    input wire logic [3:0] wrReg,
    input wire logic wrBit,
    input wire logic swReset,
    // Resolved function.
    output iocf_fn_t fn
);

    // A set bit takes the channel over; the DAC/ADC and in/out pairs merge
    // instead. A cleared bit only matters to the function owning the pin.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fn <= FN_PD;
        end else if (swReset) begin
            fn <= FN_PD;
        end else if (wrEn) begin
            case (wrReg)
                REG_DAC: begin
                    if (wrBit) begin
                        fn <= (fn == FN_ADC || fn == FN_DACADC) ? FN_DACADC : FN_DAC;
                    end else if (fn == FN_DACADC) begin
                        fn <= FN_ADC;
                    end else if (fn == FN_DAC) begin
                        fn <= FN_TRI;
                    end
                end
                REG_ADC: begin
                    if (wrBit) begin
                        fn <= (fn == FN_DAC || fn == FN_DACADC) ? FN_DACADC : FN_ADC;
                    end else if (fn == FN_DACADC) begin
                        fn <= FN_DAC;
                    end else if (fn == FN_ADC) begin
                        fn <= FN_TRI;
                    end
                end
                REG_GPO: begin
                    if (wrBit) begin
                        fn <= (fn == FN_GPI || fn == FN_GPBOTH) ? FN_GPBOTH : FN_GPO;
                    end else if (fn == FN_GPBOTH) begin
                        fn <= FN_GPI;
                    end else if (fn == FN_GPO) begin
                        fn <= FN_TRI;
                    end
                end
                REG_GPI: begin
                    if (wrBit) begin
                        fn <= (fn == FN_GPO || fn == FN_GPBOTH) ? FN_GPBOTH : FN_GPI;
                    end else if (fn == FN_GPBOTH) begin
                        fn <= FN_GPO;
                    end else if (fn == FN_GPI) begin
                        fn <= FN_TRI;
                    end
                end
                REG_PD: begin
                    if (wrBit) begin
                        fn <= FN_PD;
                    end else if (fn == FN_PD) begin
                        fn <= FN_TRI;
                    end
                end
                REG_TRI: begin
                    if (wrBit) begin
                        fn <= FN_TRI;
                    end
                end
                default: begin
                    fn <= fn;
                end
            endcase
        end
    end

endmodule

// File: rtl/iocf_top.sv
// Control registers, pin function configuration and DAC write addressing.
module iocf_top
    import iocf_pkg::*;
#(
    parameter int NUM_CH = 8
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Bytes of a write transfer, slave address already stripped.
    input wire logic frameStart,
    input wire logic byteValid,
    input wire logic [7:0] byteData,
    // Conversion status from the ADC sequencer.
    input wire logic convActive,
    // Channel pins.
    input wire logic [NUM_CH-1:0] pinIn,
    output logic [NUM_CH-1:0] pinOut,
    output logic [NUM_CH-1:0] pinOeN,
    // Analog stage controls.
    output logic adcBufPower,
    output logic adcRangeDouble,
    output logic dacRangeDouble,
    output logic [NUM_CH*DAC_CODE_W-1:0] dacCode,
    // Channel function flags.
    output logic [NUM_CH-1:0] chanIsDac,
    output logic [NUM_CH-1:0] chanIsAdc,
    output logic [NUM_CH-1:0] chanPullDown,
    output logic [NUM_CH-1:0] chanTriState,
    output logic [NUM_CH-1:0] gpioInValue,
    output logic configLocked
);

    // ------------------------------------------------------------------
    // Command assembly
    // ------------------------------------------------------------------

    logic cmdValid;           // One-cycle pulse per complete frame.
    logic [7:0] cmdPtr;       // Pointer byte of the frame.
    logic [15:0] cmdData;     // Data word, most significant byte first.

    iocf_frame_rx u_frame_rx (
        .clk(clk),
        .rst(rst),
        .frameStart(frameStart),
        .byteValid(byteValid),
        .byteData(byteData),
        .cmdValid(cmdValid),
        .cmdPtr(cmdPtr),
        .cmdData(cmdData)
    );

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------

    logic ctlWr;       // Control register write.
    logic dacWr;       // DAC input register write.
    logic pinCfgSel;   // Selected register is a pin function register.
    logic cfgAccept;   // Pin function write that is let through.
    logic swReset;     // Software reset request.
    logic [15:0] gpCtl;           // General control word.
    logic [1:0] ldacMode;         // Load transfer mode.
    logic [NUM_CH-1:0] gpioData;  // GPIO output levels.
    logic [NUM_CH-1:0] odCfg;     // Open-drain selection per pin.

    // Upper nibble zero selects a control register, one a DAC.
    assign ctlWr = cmdValid && cmdPtr[7:4] == PTR_MODE_CFG;
    assign dacWr = cmdValid && cmdPtr[7:4] == PTR_MODE_DAC;
    assign pinCfgSel = cmdPtr[3:0] == REG_ADC || cmdPtr[3:0] == REG_DAC
        || cmdPtr[3:0] == REG_PD || cmdPtr[3:0] == REG_GPO
        || cmdPtr[3:0] == REG_GPI || cmdPtr[3:0] == REG_TRI;
    // The lock only stops function changes; other control writes pass.
    assign cfgAccept = ctlWr && pinCfgSel && !gpCtl[GP_LOCK_BIT];
    assign swReset = ctlWr && cmdPtr[3:0] == REG_SWRST;

    // ------------------------------------------------------------------
    // General control word
    // ------------------------------------------------------------------

    // Only the documented bits are kept; reserved bits read back as zero,
    // so a careless host cannot switch on something undefined.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gpCtl <= GPCTL_RESET;
        end else if (swReset) begin
            gpCtl <= GPCTL_RESET;
        end else if (ctlWr && cmdPtr[3:0] == REG_GPCTL) begin
            gpCtl <= {6'h00, cmdData[9:4], 4'h0};
        end
    end

    // Load transfer mode; the pulse code is never stored but acted on.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ldacMode <= LOAD_TRANSFER_MODE_AUTO;
        end else if (swReset) begin
            ldacMode <= LOAD_TRANSFER_MODE_AUTO;
        end else if (ctlWr && cmdPtr[3:0] == REG_LOAD_TRANSFER_MODE) begin
            if (cmdData[1:0] == LOAD_TRANSFER_MODE_PULSE) begin
                ldacMode <= LOAD_TRANSFER_MODE_HOLD;
            end else if (cmdData[1:0] != 2'h3) begin
                ldacMode <= cmdData[1:0];
            end
        end
    end

    // GPIO output data and open-drain selection.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gpioData <= CFG_RESET;
            odCfg <= CFG_RESET;
        end else if (swReset) begin
            gpioData <= CFG_RESET;
            odCfg <= CFG_RESET;
        end else if (ctlWr && cmdPtr[3:0] == REG_GPDATA) begin
            gpioData <= cmdData[NUM_CH-1:0];
        end else if (ctlWr && cmdPtr[3:0] == REG_OD) begin
            odCfg <= cmdData[NUM_CH-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Channel function cells
    // ------------------------------------------------------------------

    iocf_fn_t chanFn [NUM_CH];   // Resolved function per channel.
    logic [NUM_CH-1:0] isDacFn;  // Channel currently drives a DAC.

    // Each cell sees its own data bit, so bit n steers channel n.
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_cell
        iocf_pin_cell u_cell (
            .clk(clk),
            .rst(rst),
            .wrEn(cfgAccept),
            .wrReg(cmdPtr[3:0]),
            .wrBit(cmdData[ch]),
            .swReset(swReset),
            .fn(chanFn[ch])
        );
        assign isDacFn[ch] = chanFn[ch] == FN_DAC || chanFn[ch] == FN_DACADC;
    end

    // ------------------------------------------------------------------
    // DAC input and DAC registers
    // ------------------------------------------------------------------

    logic [DAC_CODE_W-1:0] inputReg [NUM_CH];  // Staged codes.
    logic [NUM_CH-1:0] dacLoad;                // Channels written now.

    // Write-all ignores the channel address and serves DAC channels only.
    always_comb begin
        dacLoad = '0;
        if (dacWr) begin
            if (gpCtl[GP_WRALL_BIT]) begin
                dacLoad = isDacFn;
            end else begin
                dacLoad[cmdPtr[2:0]] = 1'b1;
            end
        end
    end

    // Input registers take the low twelve data bits; the address field in
    // the upper bits is ignored since the pointer already picked the target.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_CH; i++) begin
                inputReg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (dacLoad[i]) begin
                    inputReg[i] <= cmdData[DAC_CODE_W-1:0];
                end
            end
        end
    end

    // Active codes: auto mode copies the new word, a pulse copies all.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dacCode <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (ctlWr && cmdPtr[3:0] == REG_LOAD_TRANSFER_MODE && cmdData[1:0] == LOAD_TRANSFER_MODE_PULSE) begin
                    dacCode[i*DAC_CODE_W +: DAC_CODE_W] <= inputReg[i];
                end else if (dacLoad[i] && ldacMode == LOAD_TRANSFER_MODE_AUTO) begin
                    dacCode[i*DAC_CODE_W +: DAC_CODE_W] <= cmdData[DAC_CODE_W-1:0];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Analog controls and flags
    // ------------------------------------------------------------------

    // With precharge the buffer is powered only around a conversion, which
    // saves supply current at the cost of a settling tail per sample.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            adcBufPower <= 1'b0;
            adcRangeDouble <= 1'b0;
            dacRangeDouble <= 1'b0;
            configLocked <= 1'b0;
        end else begin
            adcBufPower <= gpCtl[GP_BUFEN_BIT]
                && (!gpCtl[GP_PRECHARGE_BIT] || convActive);
            adcRangeDouble <= gpCtl[GP_ADCRANGE_BIT];
            dacRangeDouble <= gpCtl[GP_DACRANGE_BIT];
            configLocked <= gpCtl[GP_LOCK_BIT];
        end
    end

    // Function flags for the analog switches.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chanIsDac <= '0;
            chanIsAdc <= '0;
            chanPullDown <= PD_RESET[NUM_CH-1:0];
            chanTriState <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                chanIsDac[i] <= isDacFn[i];
                chanIsAdc[i] <= chanFn[i] == FN_ADC || chanFn[i] == FN_DACADC;
                chanPullDown[i] <= chanFn[i] == FN_PD;
                chanTriState[i] <= chanFn[i] == FN_TRI;
            end
        end
    end

    // ------------------------------------------------------------------
    // Digital pin drive and input sampling
    // ------------------------------------------------------------------

    logic [NUM_CH-1:0] isOutFn;  // Channel drives a digital level.
    logic [NUM_CH-1:0] syncA;    // First synchroniser stage.
    logic [NUM_CH-1:0] syncB;    // Second stage.
    logic [NUM_CH-1:0] syncC;    // Third stage.

    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_out
        assign isOutFn[ch] = chanFn[ch] == FN_GPO || chanFn[ch] == FN_GPBOTH;
    end

    // Open-drain only pulls low; a high level releases the pin.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinOut <= '0;
            pinOeN <= '1;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                pinOut[i] <= odCfg[i] ? 1'b0 : gpioData[i];
                pinOeN[i] <= !(isOutFn[i] && !(odCfg[i] && gpioData[i]));
            end
        end
    end

    // Pins are asynchronous; three stages filter a level change.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            syncA <= '0;
            syncB <= '0;
            syncC <= '0;
        end else begin
            syncA <= pinIn;
            syncB <= syncA;
            syncC <= syncB;
        end
    end

    // Readback: an output channel reports its own driven level.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gpioInValue <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (isOutFn[i]) begin
                    gpioInValue[i] <= gpioData[i];
                end else if (syncB[i] == syncC[i]) begin
                    gpioInValue[i] <= syncC[i];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------

    logic [3*NUM_CH-1:0] fnVec;  // Flattened functions for checks.
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_vec
        assign fnVec[3*ch +: 3] = chanFn[ch];
    end

    chk_lock_holds_cfg: assert property (@(posedge clk) disable iff (rst)
        (ctlWr && pinCfgSel && gpCtl[GP_LOCK_BIT]) |=> $stable(fnVec))
        else $error("pin functions changed while locked");

    chk_buf_always_on: assert property (@(posedge clk) disable iff (rst)
        (gpCtl[GP_BUFEN_BIT] && !gpCtl[GP_PRECHARGE_BIT]) |=> adcBufPower)
        else $error("enabled buffer without precharge not powered");

    chk_buf_off: assert property (@(posedge clk) disable iff (rst)
        (!gpCtl[GP_BUFEN_BIT] || (gpCtl[GP_PRECHARGE_BIT] && !convActive))
        |=> !adcBufPower)
        else $error("buffer powered when it should be off");

    chk_adc_range_bit: assert property (@(posedge clk) disable iff (rst)
        (ctlWr && cmdPtr[3:0] == REG_GPCTL && !swReset)
        |=> ##1 adcRangeDouble == $past(cmdData[GP_ADCRANGE_BIT], 2))
        else $error("adc range does not follow control write");

    chk_dac_range_bit: assert property (@(posedge clk) disable iff (rst)
        (ctlWr && cmdPtr[3:0] == REG_GPCTL)
        |=> ##1 dacRangeDouble == $past(cmdData[GP_DACRANGE_BIT], 2))
        else $error("dac range does not follow control write");

    chk_load_transfer_mode_pulse_mode: assert property (@(posedge clk) disable iff (rst)
        (ctlWr && cmdPtr[3:0] == REG_LOAD_TRANSFER_MODE && cmdData[1:0] == LOAD_TRANSFER_MODE_PULSE)
        |=> ldacMode == LOAD_TRANSFER_MODE_HOLD)
        else $error("pulse mode did not return to hold");

    chk_hold_keeps_dac: assert property (@(posedge clk) disable iff (rst)
        (dacWr && ldacMode == LOAD_TRANSFER_MODE_HOLD) |=> $stable(dacCode))
        else $error("dac code changed in hold mode");

    chk_write_all_ch1: assert property (@(posedge clk) disable iff (rst)
        (dacWr && gpCtl[GP_WRALL_BIT] && isDacFn[1])
        |=> inputReg[1] == $past(cmdData[DAC_CODE_W-1:0]))
        else $error("write-all missed a dac channel");

    chk_swreset_pulldown: assert property (@(posedge clk) disable iff (rst)
        swReset |=> ##1 chanPullDown == PD_RESET[NUM_CH-1:0])
        else $error("channels not pulled down after reset");

endmodule

// File: verif/iocf_host_model.sv
// Host model that sends pointer and data bytes as write frames.
module iocf_host_model (
    // Clock.
    input wire logic clk,
    // Byte stream into the block.
    output logic frameStart,
    output logic byteValid,
    output logic [7:0] byteData
);
    timeunit 1ns;
    timeprecision 1ps;

    // -------------------------------------------------
    // Frame driver
    // -------------------------------------------------
    initial begin
        frameStart = 1'b0;
        byteValid = 1'b0;
        byteData = 8'h00;
    end

    // Callers keep reserved control bits at zero; one function write is sent while locked, to check that it is dropped.
    // After the frame the data lines show the inverse, so stale bytes never look valid.
    task automatic send(input logic [7:0] p, input logic [15:0] d);
        @(posedge clk) frameStart <= 1'b1;
        @(posedge clk) begin
            frameStart <= 1'b0;
            byteValid <= 1'b1;
            byteData <= p;
        end
        @(posedge clk) byteData <= d[15:8];
        @(posedge clk) byteData <= d[7:0];
        @(posedge clk) begin
            byteValid <= 1'b0;
            byteData <= ~d[7:0];
        end
        repeat (4) @(posedge clk);
    endtask
endmodule

// File: verif/iocf_top_tb.sv
// Self-checking testbench for the pin configuration and DAC write block.
module iocf_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // -------------------------------------------------
    // Signals
    // -------------------------------------------------
    logic clk, rst, frameStart, byteValid, convActive, adcBufPower, adcRangeDouble;
    logic dacRangeDouble, configLocked;
    logic [7:0] byteData, pinIn, pinOut, pinOeN, chanIsDac, chanIsAdc, chanPullDown;
    logic [7:0] chanTriState, gpioInValue;
    logic [95:0] dacCode;
    int n_fail = 0;
    int n_checks = 0;

    iocf_top i_dut (.clk, .rst, .frameStart, .byteValid, .byteData, .convActive, .pinIn,
        .pinOut, .pinOeN, .adcBufPower, .adcRangeDouble, .dacRangeDouble, .dacCode,
        .chanIsDac, .chanIsAdc, .chanPullDown, .chanTriState, .gpioInValue, .configLocked);
    iocf_host_model i_host (.clk, .frameStart, .byteValid, .byteData);

    // 250 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // -------------------------------------------------
    // Compare and closing tasks
    // -------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under a thousand cycles.
    initial begin
        #20000;
        n_fail++;
        stop_test();
    end

    // -------------------------------------------------
    // Test sequence
    // -------------------------------------------------
    initial begin
        rst = 1'b1;
        convActive = 1'b0;
        pinIn = 8'h00;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("pulldown", 16'h00ff, 16'(chanPullDown));
        chk("dac flags", 16'h0, 16'(chanIsDac));
        chk("analog", 16'h0, 16'({adcBufPower, adcRangeDouble, dacRangeDouble}));
        $display("test reset done");
        i_host.send(8'h03, 16'h0030);
        chk("ranges", 16'h3, 16'({adcRangeDouble, dacRangeDouble}));
        i_host.send(8'h03, 16'h0300);
        chk("buffer idle", 16'h0, 16'(adcBufPower));
        convActive <= 1'b1;
        repeat (4) @(posedge clk);
        chk("buffer conv", 16'h1, 16'(adcBufPower));
        convActive <= 1'b0;
        $display("test control done");
        i_host.send(8'h03, 16'h0080);
        i_host.send(8'h04, 16'h00ff);
        chk("locked", 16'h1, 16'(configLocked));
        chk("adc locked", 16'h0, 16'(chanIsAdc));
        i_host.send(8'h03, 16'h0000);
        i_host.send(8'h05, 16'h0082);
        chk("dac flags", 16'h0082, 16'(chanIsDac));
        chk("pulldown", 16'h007d, 16'(chanPullDown));
        i_host.send(8'h04, 16'h0002);
        chk("dac adc", 16'h0282, 16'({chanIsAdc, chanIsDac}));
        $display("test functions done");
        i_host.send(8'h12, 16'h0abc);
        chk("dac2", 16'h0abc, 16'(dacCode[35:24]));
        i_host.send(8'h03, 16'h0040);
        i_host.send(8'h10, 16'h7555);
        chk("dac1", 16'h0555, 16'(dacCode[23:12]));
        chk("dac7", 16'h0555, 16'(dacCode[95:84]));
        chk("dac2 kept", 16'h0abc, 16'(dacCode[35:24]));
        i_host.send(8'h03, 16'h0000);
        i_host.send(8'h07, 16'h0001);
        i_host.send(8'h11, 16'h0123);
        chk("dac1 held", 16'h0555, 16'(dacCode[23:12]));
        i_host.send(8'h07, 16'h0002);
        chk("dac1 pulse", 16'h0123, 16'(dacCode[23:12]));
        $display("test dac done");
        pinIn <= 8'h41;
        i_host.send(8'h08, 16'h0030);
        i_host.send(8'h0a, 16'h0020);
        i_host.send(8'h09, 16'h0030);
        i_host.send(8'h0c, 16'h0010);
        chk("pins", 16'h20df, 16'({pinOut, pinOeN}));
        chk("readback", 16'h0071, 16'(gpioInValue));
        i_host.send(8'h0d, 16'h0001);
        chk("tri pd", 16'h014c, 16'({chanTriState, chanPullDown}));
        i_host.send(8'h06, 16'h0080);
        chk("dac taken", 16'h0002, 16'(chanIsDac));
        i_host.send(8'h0f, 16'h0000);
        chk("sw pulldown", 16'h00ff, 16'(chanPullDown));
        chk("sw pins", 16'h00ff, 16'(pinOeN));
        $display("test gpio done");
        stop_test();
    end
endmodule
